// ===== logic/acsdf_top.sv
// Master clock source selection and decimation filter control with APB registers
`timescale 1ns/100ps
`include "acsdf_consts.svh"

module acsdf_top
    import acsdf_pkg::*;
#(
    parameter int NSETUP = 4,
    parameter int FIFO_DEPTH = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic int_osc_clk,
    input wire logic crystal_drive_pin_in,
    input wire logic shared_crystal_clock_pin_in,
    output logic shared_crystal_clock_pin_out,
    output logic shared_crystal_clock_pin_oe,
    input wire logic mod_bit,
    output logic mod_clk,
    output logic output_drive_boost
);
    if (NSETUP < 1 || NSETUP > 4) begin : g_chk
        $error("NSETUP must lie between 1 and 4");
    end

    // Register state
    logic [5:0] mode_r;
    logic [1:0] chan_r;
    logic [15:0] filt_r [NSETUP];
    logic [31:0] prdata_r;
    logic pready_r, pslverr_r, pin_out_r, pin_oe_r, boost_r, pop_ok_r;
    // Clock path state
    acsdf_src_t sel_src, cur_src_r;
    logic [2:0] gap_r, div_r;
    logic mod_clk_r, src_edge, mtick, mod_tick, int_level, int_rise, xtal_rise, ext_rise;
    logic [1:0] cur_code;
    // Filter state
    logic [15:0] fc;
    acsdf_filt_t filt_kind;
    logic [14:0] avg;
    logic [19:0] period, cnt_r, acc_r, acc_nxt;
    logic [1:0] skip_need, skip_r;
    logic [31:0] res_r;
    logic res_valid_r, restart_r, stall, last;
    // Bus decode
    logic setup_ph, done, wr_done, is_filt, cfg_change, fifo_in_ready, fifo_out_valid, fifo_pop;
    logic [1:0] fidx;
    logic [31:0] fifo_out_data;

    // Pin synchronisers for the three clock sources
    acsdf_pin_sync u_sync_int (.pclk(pclk), .presetn(presetn), .pin_in(int_osc_clk), .level(int_level),
        .rise(int_rise));
    acsdf_pin_sync u_sync_xtal (.pclk(pclk), .presetn(presetn), .pin_in(crystal_drive_pin_in), .level(),
        .rise(xtal_rise));
    acsdf_pin_sync u_sync_ext (.pclk(pclk), .presetn(presetn), .pin_in(shared_crystal_clock_pin_in), .level(),
        .rise(ext_rise));
    // APB phase decode
    assign setup_ph = psel && !penable;
    assign done = psel && penable && pready_r;
    assign wr_done = done && pwrite;
    assign fidx = paddr[3:2];
    assign is_filt = (paddr[7:4] == `ACSDF_ADDR_FILT_BASE) && (paddr[1:0] == 2'h0) && (32'(fidx) < NSETUP);
    assign fifo_pop = done && !pwrite && (paddr == `ACSDF_ADDR_DATA) && pop_ok_r; // Only a word captured at setup
    // Single wait-free access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
        end else begin
            pready_r <= setup_ph;
        end
    end

    // Read data and error captured during the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h0;
            pslverr_r <= 1'b0;
            pop_ok_r <= 1'b0;
        end else if (setup_ph) begin
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0;
            pop_ok_r <= 1'b0;
            if (paddr == `ACSDF_ADDR_MODE) begin
                prdata_r <= {26'h0, mode_r};
            end else if (paddr == `ACSDF_ADDR_CHAN) begin
                prdata_r <= {30'h0, chan_r};
            end else if (paddr == `ACSDF_ADDR_STATUS) begin
                prdata_r <= {27'h0, (gap_r != 3'h0), cur_code, stall, fifo_out_valid};
            end else if (paddr == `ACSDF_ADDR_DATA) begin
                prdata_r <= fifo_out_valid ? fifo_out_data : 32'h0;
                pop_ok_r <= fifo_out_valid;
            end else if (is_filt) begin
                prdata_r <= {16'h0, filt_r[fidx]};
            end else begin
                pslverr_r <= 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_r <= `ACSDF_MODE_RESET;
            chan_r <= `ACSDF_CHAN_RESET;
        end else if (wr_done) begin
            if (paddr == `ACSDF_ADDR_MODE) begin
                mode_r <= pwdata[5:0];
            end
            if (paddr == `ACSDF_ADDR_CHAN) begin
                chan_r <= (32'(pwdata[1:0]) < NSETUP) ? pwdata[1:0] : chan_r;
            end
        end
    end
    // Per-setup filter configuration words
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NSETUP; i++) begin
                filt_r[i] <= `ACSDF_FC_RESET;
            end
        end else if (wr_done && is_filt) begin
            filt_r[fidx] <= pwdata[15:0];
        end
    end

    always_comb begin
        unique case (mode_r[`ACSDF_MODE_SRC_MSB:`ACSDF_MODE_SRC_LSB])
            `ACSDF_SRC_CODE_XTAL: sel_src = src_xtal;
            `ACSDF_SRC_CODE_EXT: sel_src = src_ext;
            default: sel_src = src_int;
        endcase
    end
    // Status code of the source in use
    always_comb begin
        unique case (cur_src_r)
            src_xtal: cur_code = `ACSDF_SRC_CODE_XTAL;
            src_ext: cur_code = `ACSDF_SRC_CODE_EXT;
            default: cur_code = `ACSDF_SRC_CODE_INT;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur_src_r <= src_int;
            gap_r <= 3'h0;
        end else if (gap_r != 3'h0) begin
            gap_r <= gap_r - 3'h1;
            if (gap_r == 3'h1) begin
                cur_src_r <= sel_src;
            end
        end else if (sel_src != cur_src_r) begin
            gap_r <= `ACSDF_SWITCH_GAP;
        end
    end
    // clock edge of the source in use: oscillator, crystal or shared pin
    always_comb begin
        unique case (cur_src_r)
            src_xtal: src_edge = xtal_rise;
            src_ext: src_edge = ext_rise;
            default: src_edge = int_rise;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_r <= 3'h0;
        end else if (gap_r != 3'h0) begin
            div_r <= 3'h0;
        end else if (src_edge && cur_src_r != src_ext) begin
            div_r <= div_r + 3'h1;
        end
    end
    assign mtick = (gap_r == 3'h0) && src_edge && (cur_src_r == src_ext || div_r == `ACSDF_OSC_DIV_LAST);
    assign mod_tick = mtick && mod_clk_r;
    // Modulator clock toggles once per master tick and rests low across a swap
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mod_clk_r <= 1'b0;
        end else if (gap_r != 3'h0) begin
            mod_clk_r <= 1'b0;
        end else if (mtick) begin
            mod_clk_r <= !mod_clk_r;
        end
    end
    // internal clock out on shared pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_out_r <= 1'b0;
            pin_oe_r <= 1'b0;
            boost_r <= 1'b0;
        end else begin
            pin_oe_r <= mode_r[`ACSDF_MODE_CLKOUT_BIT] && (cur_src_r == src_int);
            pin_out_r <= mode_r[`ACSDF_MODE_CLKOUT_BIT] && (cur_src_r == src_int) && int_level;
            boost_r <= mode_r[`ACSDF_MODE_BOOST_BIT];
        end
    end
    assign fc = filt_r[chan_r];

    always_comb begin
        if (fc[`ACSDF_FC_MAP_BIT]) begin
            filt_kind = filt_direct_map;
        end else if (fc[`ACSDF_FC_ENH_BIT]) begin
            filt_kind = filt_enhanced;
        end else if (fc[6:5] == `ACSDF_FC_ORDER_SINC3) begin
            filt_kind = filt_sinc3;
        end else begin
            filt_kind = filt_sinc5_sinc1;
        end
    end

    // Sinc5 outputs averaged per result, from rate code or enhanced choice
    always_comb begin
        avg = 15'h075f;
        if (filt_kind == filt_enhanced) begin
            unique case (fc[9:8])
                2'h0: avg = 15'h047a;
                2'h1: avg = 15'h04e2;
                2'h2: avg = 15'h061a;
                default: avg = 15'h0753;
            endcase
        end else begin
            case (fc[4:0])
                5'h00: avg = 15'h0001;
                5'h01: avg = 15'h0002;
                5'h02: avg = 15'h0003;
                5'h03: avg = 15'h0006;
                5'h04: avg = 15'h000c;
                5'h05: avg = 15'h001f;
                5'h06: avg = 15'h003e;
                5'h07: avg = 15'h0052;
                5'h08: avg = 15'h009c;
                5'h09: avg = 15'h0138;
                5'h0a: avg = 15'h020d;
                5'h0b: avg = 15'h0275;
                5'h0c: avg = 15'h061a;
                default: avg = 15'h075f;
            endcase
        end
    end

    // direct map period is 32 times value
    always_comb begin
        if (filt_kind == filt_direct_map) begin
            period = {(fc[14:0] == 15'h0) ? 15'h1 : fc[14:0], `ACSDF_SINC5_SHIFT};
        end else begin
            period = {avg, `ACSDF_SINC5_SHIFT};
        end
    end
    // slow sinc5 plus sinc1 settles at once
    always_comb begin
        unique case (filt_kind)
            filt_sinc3, filt_direct_map: skip_need = `ACSDF_SKIP_SINC3;
            filt_enhanced: skip_need = `ACSDF_SKIP_NONE;
            default: skip_need = (avg >= `ACSDF_LOWRATE_AVG) ? `ACSDF_SKIP_NONE : `ACSDF_SKIP_FAST;
        endcase
    end
    // Configuration change that affects the running conversion
    assign cfg_change = wr_done && ((is_filt && fidx == chan_r) ||
                        (paddr == `ACSDF_ADDR_CHAN && pwdata[1:0] != chan_r && 32'(pwdata[1:0]) < NSETUP));
    // restart after swap or new setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            restart_r <= 1'b0;
        end else begin
            restart_r <= cfg_change || (gap_r == 3'h0 && sel_src != cur_src_r);
        end
    end
    // A finished result that the FIFO cannot take halts counting
    assign stall = res_valid_r && !fifo_in_ready;
    assign last = (cnt_r == period - 20'h1);
    assign acc_nxt = acc_r + {19'h0, mod_bit};

    // Decimation counter and bit accumulator
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= 20'h0;
            acc_r <= 20'h0;
        end else if (restart_r) begin
            cnt_r <= 20'h0;
            acc_r <= 20'h0;
        end else if (mod_tick && !stall) begin
            cnt_r <= last ? 20'h0 : cnt_r + 20'h1;
            acc_r <= last ? 20'h0 : acc_nxt;
        end
    end

    // Result issue with settling discards
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            res_valid_r <= 1'b0;
            res_r <= 32'h0;
            skip_r <= `ACSDF_SKIP_NONE;
        end else if (restart_r) begin
            res_valid_r <= 1'b0;
            skip_r <= skip_need;
        end else begin
            if (res_valid_r && fifo_in_ready) begin
                res_valid_r <= 1'b0;
            end
            if (mod_tick && !stall && last) begin
                if (skip_r != 2'h0) begin
                    skip_r <= skip_r - 2'h1;
                end else begin
                    res_valid_r <= 1'b1;
                    res_r <= {chan_r, 10'h0, acc_nxt};
                end
            end
        end
    end

    // Result buffer drained by reads of the data register
    acsdf_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH)) u_fifo (.pclk(pclk), .presetn(presetn), .in_valid(res_valid_r),
        .in_ready(fifo_in_ready), .in_data(res_r), .out_valid(fifo_out_valid), .out_ready(fifo_pop),
        .out_data(fifo_out_data));
    // Outputs straight from flip-flops
    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign shared_crystal_clock_pin_out = pin_out_r;
    assign shared_crystal_clock_pin_oe = pin_oe_r;
    assign mod_clk = mod_clk_r;
    assign output_drive_boost = boost_r;
endmodule

// ===== logic/acsdf_consts.svh
// Register map, field positions, reset values and timing counts
`ifndef ACSDF_CONSTS_SVH
`define ACSDF_CONSTS_SVH

// Register byte addresses
`define ACSDF_ADDR_MODE 8'h00
`define ACSDF_ADDR_CHAN 8'h04
`define ACSDF_ADDR_STATUS 8'h08
`define ACSDF_ADDR_DATA 8'h0c
`define ACSDF_ADDR_FILT_BASE 4'h1

// Conversion mode register fields
`define ACSDF_MODE_SRC_MSB 3
`define ACSDF_MODE_SRC_LSB 2
`define ACSDF_MODE_CLKOUT_BIT 4
`define ACSDF_MODE_BOOST_BIT 5
`define ACSDF_MODE_RESET 6'h00
`define ACSDF_CHAN_RESET 2'h0

// Clock source codes
`define ACSDF_SRC_CODE_INT 2'h0
`define ACSDF_SRC_CODE_XTAL 2'h1
`define ACSDF_SRC_CODE_EXT 2'h2

// Filter configuration word fields
`define ACSDF_FC_MAP_BIT 15
`define ACSDF_FC_ENH_BIT 11
`define ACSDF_FC_ORDER_SINC3 2'h3
`define ACSDF_FC_RESET 16'h0000

// Timing counts
`define ACSDF_OSC_DIV_LAST 3'h7
`define ACSDF_SINC5_SHIFT 5'h0
`define ACSDF_LOWRATE_AVG 15'h000c
`define ACSDF_SWITCH_GAP 3'h4
`define ACSDF_SKIP_SINC3 2'h2
`define ACSDF_SKIP_FAST 2'h1
`define ACSDF_SKIP_NONE 2'h0

`endif

// ===== logic/acsdf_pkg.sv
// Types shared by the clock select and decimation filter block
package acsdf_pkg;
    typedef enum logic [1:0] {src_int, src_xtal, src_ext} acsdf_src_t;
    typedef enum logic [1:0] {filt_sinc5_sinc1, filt_sinc3, filt_enhanced, filt_direct_map} acsdf_filt_t;
endpackage

// ===== logic/acsdf_pin_sync.sv
// Three-stage pin synchroniser with rising edge detection
`timescale 1ns/100ps

module acsdf_pin_sync (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pin_in,
    output logic level,
    output logic rise
);
    logic s1_r;
    logic s2_r;
    logic s3_r;
    logic level_r;

    // Synchroniser chain
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
        end else begin
            s1_r <= pin_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // Accepted level moves only when stages two and three agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level_r <= 1'b0;
        end else if (s2_r == s3_r) begin
            level_r <= s3_r;
        end
    end

    assign level = level_r;
    assign rise = (s2_r == s3_r) && s3_r && !level_r;
endmodule

// ===== logic/acsdf_fifo.sv
// Result FIFO with valid and ready on both sides
`timescale 1ns/100ps

module acsdf_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_chk
        $error("FIFO depth must be a power of two of at least two");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wp_r;
    logic [AW:0] rp_r;

    // Full when indices match and wrap bits differ
    assign in_ready = !((wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]));
    assign out_valid = (wp_r != rp_r);
    assign out_data = mem[rp_r[AW-1:0]];

    // Storage write
    always_ff @(posedge pclk) begin
        if (in_valid && in_ready) begin
            mem[wp_r[AW-1:0]] <= in_data;
        end
    end

    // Pointers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wp_r <= '0;
            rp_r <= '0;
        end else begin
            if (in_valid && in_ready) begin
                wp_r <= wp_r + 1'b1;
            end
            if (out_valid && out_ready) begin
                rp_r <= rp_r + 1'b1;
            end
        end
    end
endmodule

// ===== dv/acsdf_top_props.sv
// Concurrent checks on the clock select and filter block ports
`timescale 1ns/100ps

module acsdf_top_props #(
    parameter int NSETUP = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic int_osc_clk,
    input wire logic crystal_drive_pin_in,
    input wire logic shared_crystal_clock_pin_in,
    input wire logic shared_crystal_clock_pin_out,
    input wire logic shared_crystal_clock_pin_oe,
    input wire logic mod_bit,
    input wire logic mod_clk,
    input wire logic output_drive_boost
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [1:0] src_w_r;
    logic mode_wr;
    logic [7:0] top_addr;
    // Mode write strobe and first unmapped byte address
    assign mode_wr = psel && penable && pready && pwrite && (paddr == 8'h00);
    assign top_addr = 8'h10 + 8'(4 * NSETUP);
    // Last requested source, code 3 folded onto internal
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_w_r <= 2'h0;
        end else if (mode_wr) begin
            src_w_r <= (pwdata[3:2] == 2'h3) ? 2'h0 : pwdata[3:2];
        end
    end
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence gap_low_s;
        !mod_clk [*2];
    endsequence
    chk_ready_after_setup: assert property (setup_s |=> pready)
        else $error("pready missing after setup");
    chk_ready_single: assert property (pready |=> !pready)
        else $error("pready held too long");
    chk_err_unmapped: assert property (setup_s and paddr >= top_addr |=> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    chk_err_mapped: assert property (setup_s and paddr < top_addr |=> !pslverr)
        else $error("mapped access refused");
    chk_boost_follows: assert property (mode_wr |-> ##2 output_drive_boost == $past(pwdata[5], 2))
        else $error("drive boost not following mode");
    chk_pin_quiet: assert property (!shared_crystal_clock_pin_oe |-> !shared_crystal_clock_pin_out)
        else $error("pin driven while not enabled");
    chk_clkout_off: assert property (mode_wr && !pwdata[4] |-> ##2 !shared_crystal_clock_pin_oe)
        else $error("clock out left on");
    chk_gap_low: assert property (mode_wr && ((pwdata[3:2] == 2'h3 ? 2'h0 : pwdata[3:2]) != src_w_r)
        |-> ##3 gap_low_s)
        else $error("modulator clock runs in switch gap");
    chk_reset_idle: assert property ($rose(presetn) |-> !mod_clk && !shared_crystal_clock_pin_oe && !pready)
        else $error("outputs active after reset");
endmodule

// ===== dv/acsdf_clk_partner.sv
// Clock sources seen at the block's oscillator, crystal and shared pins
`timescale 1ns/100ps

module acsdf_clk_partner #(
    parameter int INT_HALF = 3,
    parameter int XTAL_HALF = 3,
    parameter int EXT_HALF = 2
) (
    input wire logic pclk,
    input wire logic int_run,
    input wire logic xtal_run,
    input wire logic ext_run,
    input wire logic pin_out,
    input wire logic pin_oe,
    output logic int_osc_clk,
    output logic crystal_drive_pin_in,
    output logic shared_crystal_clock_pin_in
);
    logic [2:0] run;
    logic [2:0] lv = 3'h0;
    int half [3] = '{INT_HALF, XTAL_HALF, EXT_HALF};
    int cnt [3] = '{0, 0, 0};
    assign run = {ext_run, xtal_run, int_run};
    // each source toggles every half period, stands still when stopped
    // crystal only oscillates once the bench lets it build up
    always @(posedge pclk) begin
        for (int i = 0; i < 3; i++) begin
            if (run[i] && cnt[i] == half[i] - 1) begin
                lv[i] <= !lv[i];
                cnt[i] <= 0;
            end else if (run[i]) begin
                cnt[i] <= cnt[i] + 1;
            end
        end
    end
    // Shared pin carries the block's clock out when it drives, else the external clock
    assign int_osc_clk = lv[0];
    assign crystal_drive_pin_in = lv[1];
    assign shared_crystal_clock_pin_in = pin_oe ? pin_out : lv[2];
endmodule

// ===== dv/adc_clock_select_and_decimation_filter_bench.sv
// Self-checking bench for the clock select and decimation filter block
`timescale 1ns/100ps
`include "acsdf_consts.svh"

module adc_clock_select_and_decimation_filter_bench;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, int_clk, xtal_clk, shared_in, pin_out, pin_oe, mod_clk, boost;
    logic xtal_run = 1'b0, ext_run = 1'b0, mod_bit = 1'b1;
    int miscompares = 0;
    int comparisons = 0;
    int cycles = 0;

    acsdf_top u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .int_osc_clk(int_clk), .crystal_drive_pin_in(xtal_clk), .shared_crystal_clock_pin_in(shared_in),
        .shared_crystal_clock_pin_out(pin_out), .shared_crystal_clock_pin_oe(pin_oe), .mod_bit(mod_bit),
        .mod_clk(mod_clk), .output_drive_boost(boost));
    acsdf_clk_partner u_src (.pclk(pclk), .int_run(1'b1), .xtal_run(xtal_run), .ext_run(ext_run),
        .pin_out(pin_out), .pin_oe(pin_oe), .int_osc_clk(int_clk), .crystal_drive_pin_in(xtal_clk),
        .shared_crystal_clock_pin_in(shared_in));

    // Clock generation
    initial begin
        forever #50 pclk = ~pclk;
    end
    // Hang guard
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            miscompares++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    // One APB transfer, then one idle edge before the next
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic set_mode(input logic [31:0] m);
        apb(1'b1, `ACSDF_ADDR_MODE, m);
        repeat (6) @(posedge pclk);
    endtask

    function automatic logic pick(input int sel);
        return (sel == 0) ? int_clk : (sel == 1) ? xtal_clk : shared_in;
    endfunction

    // Source rising edges between two modulator clock toggles
    task automatic edges_per_tick(input int sel, output int n);
        logic prev, mc;
        int guard;
        n = 0;
        guard = 0;
        mc = mod_clk;
        while (mod_clk === mc && guard < 500) begin
            @(posedge pclk);
            guard++;
        end
        mc = mod_clk;
        prev = pick(sel);
        while (mod_clk === mc && guard < 1000) begin
            @(posedge pclk);
            if (pick(sel) && !prev) n++;
            prev = pick(sel);
            guard++;
        end
    endtask

    task automatic t_reset_state();
        apb(1'b0, `ACSDF_ADDR_MODE, 32'h0);
        check(rd, 32'h0, "mode after reset");
        apb(1'b0, `ACSDF_ADDR_STATUS, 32'h0);
        check({30'h0, rd[3:2]}, {30'h0, `ACSDF_SRC_CODE_INT}, "source after reset");
        apb(1'b0, 8'h10, 32'h0);
        check(rd, 32'h0, "filter word after reset");
        apb(1'b0, 8'h40, 32'h0);
        check({rd[30:0], err}, 32'h1, "unmapped read");
    endtask

    task automatic t_internal();
        int n;
        logic prev;
        edges_per_tick(0, n);
        check(32'(n), 32'd8, "internal divide");
        set_mode(32'h30);
        check({30'h0, pin_oe, boost}, 32'h3, "clock out and boost");
        n = 0;
        prev = pin_out;
        repeat (36) begin
            @(posedge pclk);
            if (pin_out && !prev) n++;
            prev = pin_out;
        end
        check(32'(n), 32'd6, "pin carries oscillator clock");
    endtask

    task automatic t_crystal();
        int n;
        xtal_run <= 1'b1;
        set_mode(32'h14);
        apb(1'b0, `ACSDF_ADDR_STATUS, 32'h0);
        check({30'h0, rd[3:2]}, {30'h0, `ACSDF_SRC_CODE_XTAL}, "crystal in use");
        check({31'h0, pin_oe}, 32'h0, "no clock out on crystal");
        edges_per_tick(1, n);
        check(32'(n), 32'd8, "crystal divide");
    endtask

    task automatic t_external();
        int n;
        ext_run <= 1'b1;
        set_mode(32'h0c);
        apb(1'b0, `ACSDF_ADDR_STATUS, 32'h0);
        check({30'h0, rd[3:2]}, {30'h0, `ACSDF_SRC_CODE_INT}, "code three is internal");
        set_mode(32'h08);
        apb(1'b0, `ACSDF_ADDR_STATUS, 32'h0);
        check({30'h0, rd[3:2]}, {30'h0, `ACSDF_SRC_CODE_EXT}, "external in use");
        edges_per_tick(2, n);
        check(32'(n), 32'd1, "external edge per tick");
    endtask

    // Direct-map filter on setup 1: fill until stall, stop the source, drain
    task automatic t_convert();
        int n;
        apb(1'b1, 8'h14, 32'h8002);
        apb(1'b1, `ACSDF_ADDR_CHAN, 32'h1);
        n = 0;
        do begin
            apb(1'b0, `ACSDF_ADDR_DATA, 32'h0);
            apb(1'b0, `ACSDF_ADDR_STATUS, 32'h0);
            n++;
        end while (rd[0] && n < 40);
        n = 0;
        do begin
            apb(1'b0, `ACSDF_ADDR_STATUS, 32'h0);
            n++;
        end while (!rd[1] && n < 5000);
        check({30'h0, rd[1:0]}, 32'h3, "fifo full and stalled");
        ext_run <= 1'b0;
        n = 0;
        repeat (30) begin
            apb(1'b0, `ACSDF_ADDR_STATUS, 32'h0);
            if (rd[0]) begin
                apb(1'b0, `ACSDF_ADDR_DATA, 32'h0);
                check(rd, 32'h40000040, "mapped result");
                n++;
            end
        end
        check(32'(n), 32'd17, "all results kept");
        apb(1'b0, `ACSDF_ADDR_DATA, 32'h0);
        check(rd, 32'h0, "empty read");
    endtask

    // Main sequence
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset_state();
        t_internal();
        t_crystal();
        t_external();
        t_convert();
        tally_and_finish();
    end
endmodule

bind acsdf_top acsdf_top_props #(.NSETUP(NSETUP)) u_props (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .int_osc_clk(int_osc_clk), .crystal_drive_pin_in(crystal_drive_pin_in),
    .shared_crystal_clock_pin_in(shared_crystal_clock_pin_in), .mod_bit(mod_bit), .mod_clk(mod_clk),
    .shared_crystal_clock_pin_out(shared_crystal_clock_pin_out), .output_drive_boost(output_drive_boost),
    .shared_crystal_clock_pin_oe(shared_crystal_clock_pin_oe));
